/* inc/sfh_map.vh */
// What this block does
// - Opcode, address and data bytes travel most significant bit first.
// - Each frame is one opcode then any of address, dummy and data bytes, or nothing.
// - Host raises select only after a whole output byte of a read.
// - Opcode 06h alone sets the write-enable latch.
// - Opcode 04h clears the write-enable latch, as do 01h, 02h, D8h and C7h at the end of their frames.
// - Opcode 9Fh returns one to twenty identification bytes.
// - Opcode 05h returns the status byte as long as clocks come.
// - Opcode 01h is followed by exactly one status data byte.
// - Opcode 03h takes three address bytes then streams array data.
// - Opcode 0Bh takes three address bytes and one dummy, then streams.
// - 02h: address plus 1 to 256 bytes; D8h: address; C7h: nothing.
// - B9h powers down; ABh wakes, with three dummies returns signature.
// - Latch-set must precede each program, erase and status write.
`ifndef SFH_MAP_VH
`define SFH_MAP_VH
`define SFH_OP_LATCH_SET 8'h06
`define SFH_OP_LATCH_CLEAR 8'h04
`define SFH_OP_IDENT_READ 8'h9f
`define SFH_OP_STATUS_READ 8'h05
`define SFH_OP_STATUS_WRITE 8'h01
`define SFH_OP_ARRAY_READ 8'h03
`define SFH_OP_FAST_READ 8'h0b
`define SFH_OP_PAGE_PROGRAM 8'h02
`define SFH_OP_SECTOR_ERASE 8'hd8
`define SFH_OP_WHOLE_ERASE 8'hc7
`define SFH_OP_POWER_DOWN 8'hb9
`define SFH_OP_WAKE_SIGNATURE 8'hab
`define SFH_ADDR_MASK 24'h3f_ffff
`define SFH_ADDR_BYTES 2'h3
`define SFH_FAST_DUMMY 2'h1
`define SFH_WAKE_DUMMY 2'h3
`define SFH_IDENT_MAX 16'h0014
`define SFH_PAGE_MAX 16'h0100
`define SFH_CLK_PERIOD_NS 20
`define SFH_SCK_PERIOD_NS 160
`define SFH_DESELECT_NS 100
`define SFH_FIFO_DEPTH 16
`endif

/* logic/sfh_host.v */
`timescale 1ns/10ps
`include "sfh_map.vh"

module sfh_fifo #(
  parameter W = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire clr_i,
  input wire [W-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [W-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr_reg;
  reg [AW:0] rptr_reg;
  wire full;
  wire empty;
  wire push;
  wire pop;

  assign empty = wptr_reg == rptr_reg;
  assign full = (wptr_reg[AW] != rptr_reg[AW]) &&
                (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rptr_reg[AW-1:0]];
  assign push = in_valid_i && !full && !clr_i;
  assign pop = out_ready_i && !empty && !clr_i;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_reg <= {(AW+1){1'b0}};
      rptr_reg <= {(AW+1){1'b0}};
    end else if (clr_i) begin
      wptr_reg <= {(AW+1){1'b0}};
      rptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule // sfh_fifo

module sfh_host #(
  parameter SCK_HALF = `SFH_SCK_PERIOD_NS / (2 * `SFH_CLK_PERIOD_NS),
  parameter GAP_CYC = (`SFH_DESELECT_NS + `SFH_CLK_PERIOD_NS - 1) /
                      `SFH_CLK_PERIOD_NS,
  parameter FIFO_DEPTH = `SFH_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  output wire cmd_ready_o,
  input wire [7:0] cmd_op_i,
  input wire [23:0] cmd_addr_i,
  input wire [15:0] cmd_len_i,
  input wire [7:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  output wire [7:0] rd_data_o,
  output wire rd_valid_o,
  output wire done_o,
  output wire refused_o,
  output wire busy_o,
  output wire spi_cs_n_o,
  output wire spi_sck_o,
  output wire spi_mosi_o,
  input wire spi_miso_i
);
  localparam ST_IDLE = 3'd0;
  localparam ST_LOAD = 3'd1;
  localparam ST_SHIFT = 3'd2;
  localparam ST_TAIL = 3'd3;
  localparam ST_GAP = 3'd4;
  localparam [7:0] TICK_LAST = SCK_HALF - 1;
  localparam [7:0] GAP_LAST = GAP_CYC - 1;
  localparam [15:0] PAGE_MAX = `SFH_PAGE_MAX;

  reg [2:0] state_reg;
  reg [7:0] op_reg;
  reg [23:0] addr_reg;
  reg [1:0] na_reg;
  reg [1:0] nd_reg;
  reg [8:0] ntx_reg;
  reg [16:0] total_reg;
  reg [16:0] idx_reg;
  reg [2:0] bit_reg;
  reg [7:0] div_reg;
  reg sck_reg;
  reg cs_n_reg;
  reg [7:0] sh_reg;
  reg [7:0] rx_reg;
  reg [7:0] rd_data_reg;
  reg rd_valid_reg;
  reg done_reg;
  reg refused_reg;
  reg wel_reg;
  reg pd_reg;
  reg miso_meta_reg;
  reg miso_sync_reg;

  reg [1:0] d_na;
  reg [1:0] d_nd;
  reg [8:0] d_ntx;
  reg [15:0] d_nrx;
  reg d_ok;
  reg d_wr;
  reg [7:0] next_byte;
  reg need_fifo;

  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire fifo_clr;
  wire accept;
  wire refuse;
  wire tick;
  wire [16:0] hdr_end;
  wire [16:0] tx_end;
  wire [15:0] rd_len;

  assign cmd_ready_o = state_reg == ST_IDLE;
  assign accept = cmd_valid_i && cmd_ready_o;
  // Latch-set first; writes in power-down are pointless
  // write gating
  assign refuse = accept && (!d_ok || (d_wr && (!wel_reg || pd_reg)));
  assign fifo_clr = refuse && (d_ntx != 9'd0);
  assign tick = div_reg == TICK_LAST;
  assign hdr_end = {15'd0, na_reg} + {15'd0, nd_reg};
  assign tx_end = hdr_end + {8'd0, ntx_reg};
  assign fifo_pop = (state_reg == ST_LOAD) && need_fifo && fifo_valid;
  // Reads move at least one byte
  assign rd_len = (cmd_len_i == 16'd0) ? 16'd1 : cmd_len_i;

  assign busy_o = state_reg != ST_IDLE;
  assign spi_cs_n_o = cs_n_reg;
  assign spi_sck_o = sck_reg;
  assign spi_mosi_o = sh_reg[7];
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign done_o = done_reg;
  assign refused_o = refused_reg;

  sfh_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_wr_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(fifo_clr),
    .in_data_i(wr_data_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // Frame layout per opcode
  // frame layout
  always @* begin
    d_na = 2'd0;
    d_nd = 2'd0;
    d_ntx = 9'd0;
    d_nrx = 16'd0;
    d_ok = 1'b1;
    d_wr = 1'b0;
    case (cmd_op_i)
      `SFH_OP_LATCH_SET: begin
        d_ok = 1'b1;
      end
      `SFH_OP_LATCH_CLEAR: begin
        d_ok = 1'b1;
      end
      `SFH_OP_IDENT_READ: begin
        d_nrx = (rd_len > `SFH_IDENT_MAX) ? `SFH_IDENT_MAX : rd_len;
      end
      `SFH_OP_STATUS_READ: begin
        d_nrx = rd_len;
      end
      `SFH_OP_STATUS_WRITE: begin
        d_ntx = 9'd1;
        d_wr = 1'b1;
      end
      `SFH_OP_ARRAY_READ: begin
        d_na = `SFH_ADDR_BYTES;
        d_nrx = rd_len;
      end
      `SFH_OP_FAST_READ: begin
        d_na = `SFH_ADDR_BYTES;
        d_nd = `SFH_FAST_DUMMY;
        d_nrx = rd_len;
      end
      `SFH_OP_PAGE_PROGRAM: begin
        d_na = `SFH_ADDR_BYTES;
        d_wr = 1'b1;
        if (rd_len > `SFH_PAGE_MAX) begin
          d_ntx = PAGE_MAX[8:0];
        end else begin
          d_ntx = rd_len[8:0];
        end
      end
      `SFH_OP_SECTOR_ERASE: begin
        d_na = `SFH_ADDR_BYTES;
        d_wr = 1'b1;
      end
      `SFH_OP_WHOLE_ERASE: begin
        d_wr = 1'b1;
      end
      `SFH_OP_POWER_DOWN: begin
        d_ok = 1'b1;
      end
      `SFH_OP_WAKE_SIGNATURE: begin
        if (cmd_len_i != 16'd0) begin
          d_nd = `SFH_WAKE_DUMMY;
          d_nrx = cmd_len_i;
        end
      end
      default: begin
        d_ok = 1'b0;
      end
    endcase
  end

  // Byte to shift out at position idx_reg
  always @* begin
    next_byte = 8'h00;
    need_fifo = 1'b0;
    if (idx_reg == 17'd0) begin
      next_byte = op_reg;
    end else if (idx_reg <= {15'd0, na_reg}) begin
      case (na_reg - idx_reg[1:0])
        2'd2: next_byte = addr_reg[23:16];
        2'd1: next_byte = addr_reg[15:8];
        default: next_byte = addr_reg[7:0];
      endcase
    end else if (idx_reg > hdr_end && idx_reg <= tx_end) begin
      next_byte = fifo_data;
      need_fifo = 1'b1;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
    end else begin
      miso_meta_reg <= spi_miso_i;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      op_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      na_reg <= 2'd0;
      nd_reg <= 2'd0;
      ntx_reg <= 9'd0;
      total_reg <= 17'd0;
      idx_reg <= 17'd0;
      bit_reg <= 3'd0;
      div_reg <= 8'd0;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      wel_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (refuse) begin
            refused_reg <= 1'b1;
          end else if (accept) begin
            op_reg <= cmd_op_i;
            addr_reg <= cmd_addr_i & `SFH_ADDR_MASK;
            na_reg <= d_na;
            nd_reg <= d_nd;
            ntx_reg <= d_ntx;
            total_reg <= 17'd1 + {15'd0, d_na} + {15'd0, d_nd} +
                         {8'd0, d_ntx} + {1'b0, d_nrx};
            idx_reg <= 17'd0;
            cs_n_reg <= 1'b0;
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Stall with clock low until program data arrives
          if (!need_fifo || fifo_valid) begin
            sh_reg <= next_byte;
            idx_reg <= idx_reg + 17'd1;
            bit_reg <= 3'd0;
            div_reg <= 8'd0;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!tick) begin
            div_reg <= div_reg + 8'd1;
          end else begin
            div_reg <= 8'd0;
            if (!sck_reg) begin
              sck_reg <= 1'b1;
              rx_reg <= {rx_reg[6:0], miso_sync_reg};
            end else begin
              sck_reg <= 1'b0;
              if (bit_reg == 3'd7) begin
                if (idx_reg > tx_end + 17'd1) begin
                  rd_data_reg <= rx_reg;
                  rd_valid_reg <= 1'b1;
                end
                if (idx_reg == total_reg) begin
                  state_reg <= ST_TAIL;
                end else begin
                  state_reg <= ST_LOAD;
                end
              end else begin
                sh_reg <= {sh_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 3'd1;
              end
            end
          end
        end
        ST_TAIL: begin
          // Select rises only after whole bytes
          // byte boundary
          if (!tick) begin
            div_reg <= div_reg + 8'd1;
          end else begin
            div_reg <= 8'd0;
            cs_n_reg <= 1'b1;
            sh_reg <= 8'h00;
            state_reg <= ST_GAP;
            case (op_reg)
              `SFH_OP_LATCH_SET: wel_reg <= 1'b1;
              `SFH_OP_POWER_DOWN: pd_reg <= 1'b1;
              `SFH_OP_WAKE_SIGNATURE: pd_reg <= 1'b0;
              `SFH_OP_LATCH_CLEAR,
              `SFH_OP_STATUS_WRITE,
              `SFH_OP_PAGE_PROGRAM,
              `SFH_OP_SECTOR_ERASE,
              `SFH_OP_WHOLE_ERASE: begin
                wel_reg <= 1'b0;
              end
              default: wel_reg <= wel_reg;
            endcase
          end
        end
        ST_GAP: begin
          // Frame ends here, select high after last byte
          // end of frame
          if (div_reg == GAP_LAST) begin
            div_reg <= 8'd0;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            div_reg <= div_reg + 8'd1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cs_n_reg <= 1'b1;
          sck_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule // sfh_host

/* tb/sfh_host_props.sv */
`timescale 1ns/10ps
module sfh_host_props (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire cmd_valid_i,
  input wire cmd_ready_o,
  input wire [7:0] cmd_op_i,
  input wire [23:0] cmd_addr_i,
  input wire [15:0] cmd_len_i,
  input wire [7:0] wr_data_i,
  input wire wr_valid_i,
  input wire wr_ready_o,
  input wire [7:0] rd_data_o,
  input wire rd_valid_o,
  input wire done_o,
  input wire refused_o,
  input wire busy_o,
  input wire spi_cs_n_o,
  input wire spi_sck_o,
  input wire spi_mosi_o,
  input wire spi_miso_i
);
  reg [2:0] edge_reg;
  reg sck_q_reg;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Rising serial clock edges within the current frame, modulo eight
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_reg <= 3'h0;
      sck_q_reg <= 1'b0;
    end else begin
      sck_q_reg <= spi_sck_o;
      if (spi_cs_n_o)
        edge_reg <= 3'h0;
      else if (spi_sck_o && !sck_q_reg)
        edge_reg <= edge_reg + 3'h1;
    end
  end
  property p_idle_quiet;
    cmd_ready_o |-> spi_cs_n_o && !busy_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("select active while idle");
  // A taken request is either refused or starts a frame
  property p_take;
    cmd_valid_i && cmd_ready_o |=> refused_o || (!cmd_ready_o && busy_o);
  endproperty
  a_take: assert property (p_take)
    else $error("command not taken");
  property p_refuse_cause;
    refused_o |-> $past(cmd_valid_i) && $past(cmd_ready_o);
  endproperty
  a_refuse_cause: assert property (p_refuse_cause)
    else $error("refusal without a request");
  property p_refuse_quiet;
    refused_o |-> spi_cs_n_o ##1 spi_cs_n_o;
  endproperty
  a_refuse_quiet: assert property (p_refuse_quiet)
    else $error("select driven on refusal");
  property p_sck_high;
    $rose(spi_sck_o) |-> spi_sck_o[*4] ##1 !spi_sck_o;
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("serial clock high phase wrong");
  property p_mosi_hold;
    spi_sck_o |-> $stable(spi_mosi_o);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("data moved while clock high");
  property p_cs_sck;
    spi_cs_n_o |-> !spi_sck_o;
  endproperty
  a_cs_sck: assert property (p_cs_sck)
    else $error("clock high while deselected");
  property p_done_gap;
    $rose(spi_cs_n_o) |-> ##[1:8] done_o;
  endproperty
  a_done_gap: assert property (p_done_gap)
    else $error("no done after frame");
  property p_byte_frame;
    $rose(spi_cs_n_o) |-> edge_reg == 3'h0;
  endproperty
  a_byte_frame: assert property (p_byte_frame)
    else $error("frame not on byte boundary");
endmodule // sfh_host_props
bind sfh_host sfh_host_props i_props (.core_clk_i, .rst_n_i, .cmd_valid_i,
  .cmd_ready_o, .cmd_op_i, .cmd_addr_i, .cmd_len_i, .wr_data_i, .wr_valid_i,
  .wr_ready_o, .rd_data_o, .rd_valid_o, .done_o, .refused_o, .busy_o,
  .spi_cs_n_o, .spi_sck_o, .spi_mosi_o, .spi_miso_i);

/* tb/sfh_flash_model.sv */
`timescale 1ns/10ps
module sfh_flash_model #(
  parameter MFR = 8'h5a,
  parameter TYP = 8'h3c,
  parameter CAP = 8'h66,
  parameter SIG = 8'ha5,
  parameter BUSY_NS = 3000
) (
  input wire spi_cs_n_i,
  input wire spi_sck_i,
  input wire spi_mosi_i,
  output reg spi_miso_o = 1'b0
);
  // Identity values are arbitrary
  reg [7:0] mem [int];
  reg [7:0] pq [$];
  reg [7:0] sh, wd, ob;
  reg [7:0] op = 8'h00, sr = 8'h00;
  reg [23:0] ad;
  reg write_enable_latch = 1'b0, pd = 1'b0;
  int nb = 0, h, i;
  time bz = 0;
  function automatic bit cycle_in_progress_flag();
    return $time < bz;
  endfunction
  function automatic [7:0] rdm(input int x);
    return mem.exists(x) ? mem[x] : 8'hff;
  endfunction
  // busy gives no output except status read; unknown gives none
  function automatic int hdr();
    case (op)
      8'h05: return 8;
      8'h9f: return cycle_in_progress_flag() ? 99999 : 8;
      8'h03, 8'hab: return cycle_in_progress_flag() ? 99999 : 32;
      8'h0b: return cycle_in_progress_flag() ? 99999 : 40;
      default: return 99999;
    endcase
  endfunction
  function automatic [7:0] dout(input int j);
    case (op)
      8'h05: return {sr[7], 2'b00, sr[4:2], write_enable_latch, cycle_in_progress_flag()};
      8'h9f: return j == 0 ? MFR : j == 1 ? TYP : j == 2 ? CAP :
        j == 3 ? 8'h10 : 8'h00;
      8'hab: return SIG;
      default: return rdm((ad + j) & 32'h3f_ffff);
    endcase
  endfunction
  task automatic exec();
    if (op == 8'h01 && nb == 16)
      sr = wd & 8'h9c;
    else if (op == 8'h02 && nb > 32)
      for (h = 0; h < pq.size(); h++) begin
        i = {ad[21:8], ad[7:0] + h[7:0]};
        mem[i] = rdm(i) & pq[h];
      end
    else if (op == 8'hd8 && nb == 32)
      for (h = 0; h < 65536; h++)
        mem.delete({ad[21:16], h[15:0]});
    else if (op == 8'hc7 && nb == 8)
      mem.delete();
    else
      return;
    write_enable_latch = 1'b0;
    bz = $time + BUSY_NS;
  endtask
  always @(posedge spi_sck_i) begin
    if (!spi_cs_n_i) begin
      sh = {sh[6:0], spi_mosi_i};
      nb = nb + 1;
      if (nb == 8)
        op = sh;
      if (nb > 8 && nb <= 32 && nb % 8 == 0)
        ad = {ad[15:0], sh};
      if (nb == 16)
        wd = sh;
      if (nb > 32 && nb % 8 == 0)
        pq.push_back(sh);
    end
  end
  always @(negedge spi_sck_i) begin
    h = hdr();
    if (!spi_cs_n_i && nb >= h) begin
      ob = dout((nb - h) / 8);
      spi_miso_o = ob[7 - (nb - h) % 8];
    end
  end
  always @(posedge spi_cs_n_i) begin
    spi_miso_o = ~spi_miso_o;
    if (nb % 8 == 0 && nb > 0 && !cycle_in_progress_flag()) begin
      case (op)
        8'h06: write_enable_latch = 1'b1;
        8'h04: write_enable_latch = 1'b0;
        8'hb9: pd = 1'b1;
        8'hab: pd = 1'b0;
        default: if (write_enable_latch && !pd) exec();
      endcase
    end
    nb = 0;
    pq.delete();
  end
endmodule // sfh_flash_model

/* tb/sfh_host_test.sv */
`timescale 1ns/10ps
module sfh_host_test;
  // Identity values are arbitrary, matched to the partner model
  localparam [31:0] IDW = {8'h5a, 8'h3c, 8'h66, 8'h10};
  localparam [7:0] SIG = 8'ha5;
  reg clk = 0, rst_n = 0, cv = 0, wv = 0, r;
  reg [7:0] cop = 0, wd = 0;
  reg [23:0] cad = 0;
  reg [15:0] clen = 0;
  wire cr, wr, rv, dn, rf, cs_n, sck, mosi, miso;
  wire [7:0] rd;
  int n_errors = 0, n_checks = 0, k, i, j;
  reg [7:0] rx [$];
  reg [7:0] wq [$];
  reg [7:0] bm [int];
  always #10 clk = ~clk;
  always @(posedge clk) if (rv === 1'b1) rx.push_back(rd);
  sfh_host i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
    .cmd_ready_o(cr), .cmd_op_i(cop), .cmd_addr_i(cad), .cmd_len_i(clen),
    .wr_data_i(wd), .wr_valid_i(wv), .wr_ready_o(wr), .rd_data_o(rd),
    .rd_valid_o(rv), .done_o(dn), .refused_o(rf), .busy_o(),
    .spi_cs_n_o(cs_n), .spi_sck_o(sck), .spi_mosi_o(mosi), .spi_miso_i(miso));
  sfh_flash_model #(.MFR(IDW[31:24]), .TYP(IDW[23:16]), .CAP(IDW[15:8]),
    .SIG(SIG)) i_mem (.spi_cs_n_i(cs_n), .spi_sck_i(sck),
    .spi_mosi_i(mosi), .spi_miso_o(miso));
  function automatic [7:0] bmr(input int x);
    return bm.exists(x) ? bm[x] : 8'hff;
  endfunction
  task chk(input string s, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task results;
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task lim(input int n);
    if (k >= n) begin
      n_errors++;
      results;
    end
  endtask
  task cmd(input [7:0] op, input [23:0] ad, input [15:0] ln);
    @(negedge clk);
    rx.delete();
    {cv, cop, cad, clen} = {1'b1, op, ad, ln};
    for (k = 0; cr !== 1'b1 && k < 99; k++) @(negedge clk);
    lim(99);
    @(negedge clk);
    cv = 0;
    for (k = 0; dn !== 1'b1 && rf !== 1'b1 && k < 30000; k++)
      @(negedge clk);
    lim(30000);
    r = rf;
  endtask
  task poll;
    for (j = 0; j < 60; j++) begin
      cmd(8'h05, 0, 1);
      if (rx[0][0] === 1'b0) break;
    end
    k = j;
    lim(60);
  endtask
  // Fill the write buffer until it refuses, then program it as one page
  task prog(input [23:0] a);
    wq.delete();
    @(negedge clk);
    while (wr === 1'b1 && wq.size() < 40) begin
      wd = 8'($urandom);
      wv = 1;
      wq.push_back(wd);
      @(negedge clk);
    end
    wv = 0;
    chk("fifo depth", 16, wq.size());
    cmd(8'h06, 0, 0);
    cmd(8'h02, a, 16);
    chk("program refused", 0, r);
    for (i = 0; i < 16; i++) bm[a + i] = bmr(a + i) & wq[i];
    poll;
    cmd(8'h03, a, 16);
    for (i = 0; i < 16; i++) chk("read", bmr(a + i), rx[i]);
  endtask
  initial begin
    k = $urandom(39);
    repeat (12) @(negedge clk);
    rst_n = 1;
    cmd(8'h9f, 0, 25);
    chk("ident count", 20, rx.size());
    for (i = 0; i < 20; i++)
      chk("ident", i < 4 ? IDW[31 - 8 * i -: 8] : 0, rx[i]);
    cmd(8'h9f, 0, 2);
    chk("ident cut", 2, rx.size());
    cmd(8'h55, 0, 1);
    chk("unknown refused", 1, r);
    cmd(8'h02, 0, 1);
    chk("unlatched refused", 1, r);
    cmd(8'h06, 0, 0);
    cmd(8'h05, 0, 3);
    chk("latch set", 8'h02, rx[2]);
    cmd(8'h04, 0, 0);
    cmd(8'h05, 0, 1);
    chk("latch clear", 8'h00, rx[0]);
    prog(24'h3f_fff0);
    prog(24'h3f_fff0);
    cmd(8'h02, 24'h3f_fff0, 1);
    chk("latch consumed", 1, r);
    cmd(8'h0b, 24'h3f_fffe, 3);
    for (i = 0; i < 3; i++)
      chk("fast", bmr((32'h3f_fffe + i) & 32'h3f_ffff), rx[i]);
    cmd(8'h06, 0, 0);
    cmd(8'hd8, 24'h3f_1234, 0);
    poll;
    bm.delete();
    cmd(8'h03, 24'h3f_fff0, 1);
    chk("erased", 8'hff, rx[0]);
    wd = 8'h1c;
    wv = 1;
    @(negedge clk);
    wv = 0;
    cmd(8'h06, 0, 0);
    cmd(8'h01, 0, 1);
    poll;
    chk("status write", 8'h1c, rx[0]);
    cmd(8'hb9, 0, 0);
    cmd(8'h06, 0, 0);
    cmd(8'hc7, 0, 0);
    chk("asleep refused", 1, r);
    cmd(8'hab, 0, 2);
    chk("signature", {SIG, SIG}, {rx[0], rx[1]});
    cmd(8'h06, 0, 0);
    cmd(8'hc7, 0, 0);
    chk("bulk erase", 0, r);
    poll;
    // Release without signature must also leave power-down
    cmd(8'hb9, 0, 0);
    cmd(8'hab, 0, 0);
    cmd(8'h06, 0, 0);
    cmd(8'hd8, 24'h00_0000, 0);
    chk("released", 0, r);
    poll;
    chk("erase clears latch", 8'h1c, rx[0]);
    results;
  end
endmodule // sfh_host_test
